/* rtl/adcsw_pkg.sv */
package adcsw_pkg;

  // control register location and reset value
  localparam logic [7:0] ADCSW_CTRL_ADDR  = 8'he8;
  localparam logic [7:0] ADCSW_CTRL_RESET = 8'h00;

  // control register field positions
  localparam int ADCSW_EN_BIT   = 7;
  localparam int ADCSW_TM_BIT   = 6;
  localparam int ADCSW_DONE_BIT = 5;
  localparam int ADCSW_BUSY_BIT = 4;
  localparam int ADCSW_WIN_BIT  = 3;
  localparam int ADCSW_CM_LSB   = 0;
  localparam int ADCSW_CM_W     = 3;

  // start-mode field codes
  localparam logic [2:0] ADCSW_CM_BUSY_WRITE = 3'h0;
  localparam logic [2:0] ADCSW_CM_TIMER0     = 3'h1;
  localparam logic [2:0] ADCSW_CM_TIMER2     = 3'h2;
  localparam logic [2:0] ADCSW_CM_TIMER1     = 3'h3;
  localparam logic [2:0] ADCSW_CM_EXT_PIN    = 3'h4;
  localparam logic [2:0] ADCSW_CM_TIMER3     = 3'h5;

  // low-power tracking length in converter clocks
  localparam int         ADCSW_LP_TRACK_CLKS = 3;
  localparam logic [1:0] ADCSW_LP_TRACK_LAST = 2'(ADCSW_LP_TRACK_CLKS - 1);

  // result width
  localparam int ADCSW_RESULT_W = 10;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TRACK,
    ST_CONVERT
  } adcsw_state_t;

endpackage : adcsw_pkg

/* rtl/adcsw_sync.sv */
`timescale 1ns/1ps
module adcsw_sync (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : adcsw_sync

/* rtl/adcsw_window.sv */
`timescale 1ns/1ps
module adcsw_window #(
  parameter int W = 10
) (
  input  wire logic [W-1:0] sample,
  input  wire logic [W-1:0] gt_limit,
  input  wire logic [W-1:0] lt_limit,
  input  wire logic         outside,
  output logic              match
);
  logic above_gt;
  logic below_lt;
  logic below_gt;
  logic above_lt;

  // all operands compared as unsigned words of equal width
  always_comb begin
    above_gt = sample > gt_limit;
    below_lt = sample < lt_limit;
    below_gt = sample < gt_limit;
    above_lt = sample > lt_limit;
    if (outside) begin
      match = below_gt || above_lt;
    end else begin
      match = above_gt && below_lt;
    end
  end

endmodule : adcsw_window

/* rtl/adcsw_ctrl.sv */
`timescale 1ns/1ps
module adcsw_ctrl (
  input  wire logic                                mclk,
  input  wire logic                                rst_n,
  input  wire logic [7:0]                          sfr_addr,
  input  wire logic                                sfr_wr,
  input  wire logic [7:0]                          sfr_wdata,
  output logic [7:0]                               sfr_rdata,
  input  wire logic                                window_outside,
  input  wire logic [adcsw_pkg::ADCSW_RESULT_W-1:0] less_than_limit,
  input  wire logic [adcsw_pkg::ADCSW_RESULT_W-1:0] greater_than_limit,
  input  wire logic                                timer0_ovf,
  input  wire logic                                timer1_ovf,
  input  wire logic                                timer2_ovf,
  input  wire logic                                timer3_ovf,
  input  wire logic                                external_start_pin,
  input  wire logic                                sar_clk_tick,
  input  wire logic                                core_done,
  input  wire logic [adcsw_pkg::ADCSW_RESULT_W-1:0] core_result,
  output logic                                     core_enable,
  output logic                                     core_track,
  output logic                                     core_start,
  output logic [adcsw_pkg::ADCSW_RESULT_W-1:0]     conversion_result
);
  import adcsw_pkg::*;

  adcsw_state_t              state_q, state_d;
  logic [1:0]                cnt_q, cnt_d;
  logic                      en_q, en_d;
  logic                      tm_q, tm_d;
  logic [ADCSW_CM_W-1:0]     cm_q, cm_d;
  logic                      done_q, done_d;
  logic                      win_q, win_d;
  logic [ADCSW_RESULT_W-1:0] result_q, result_d;
  logic                      ext_prev_q, ext_prev_d;
  logic                      ext_sync;
  logic                      ext_rise;
  logic                      ctrl_wr;
  logic                      busy_wr;
  logic                      trigger;
  logic                      conv_end;
  logic                      win_match;
  logic                      busy;

  // trigger decoding by start-mode code
  function automatic logic adcsw_trigger(
    input logic [2:0] mode,
    input logic       bw,
    input logic       t0,
    input logic       t1,
    input logic       t2,
    input logic       t3,
    input logic       rise
  );
    logic hit;
    hit = 1'b0;
    case (mode)
      ADCSW_CM_BUSY_WRITE: hit = bw;
      ADCSW_CM_TIMER0:     hit = t0;
      ADCSW_CM_TIMER2:     hit = t2;
      ADCSW_CM_TIMER1:     hit = t1;
      ADCSW_CM_EXT_PIN:    hit = rise;
      ADCSW_CM_TIMER3:     hit = t3;
      default:             hit = 1'b0;
    endcase
    return hit;
  endfunction : adcsw_trigger

  adcsw_sync u_ext_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (external_start_pin),
    .sync_out (ext_sync)
  );

  adcsw_window #(
    .W (ADCSW_RESULT_W)
  ) u_window (
    .sample   (core_result),
    .gt_limit (greater_than_limit),
    .lt_limit (less_than_limit),
    .outside  (window_outside),
    .match    (win_match)
  );

  assign busy     = (state_q == ST_CONVERT);
  assign ctrl_wr  = sfr_wr && (sfr_addr == ADCSW_CTRL_ADDR);
  assign busy_wr  = ctrl_wr && sfr_wdata[ADCSW_BUSY_BIT];
  assign ext_rise = ext_sync && !ext_prev_q;
  assign conv_end = busy && core_done;
  assign trigger  = adcsw_trigger(cm_q, busy_wr, timer0_ovf, timer1_ovf,
                                  timer2_ovf, timer3_ovf, ext_rise);

  // sequencing of track and convert phases
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    core_start = 1'b0;
    ext_prev_d = ext_sync;
    case (state_q)
      ST_IDLE: begin
        if (en_q && trigger) begin
          if (!tm_q || cm_q == ADCSW_CM_EXT_PIN) begin
            state_d    = ST_CONVERT;
            core_start = 1'b1;
          end else begin
            state_d = ST_TRACK;
            cnt_d   = 2'h0;
          end
        end
      end
      ST_TRACK: begin
        if (sar_clk_tick) begin
          if (cnt_q == ADCSW_LP_TRACK_LAST) begin
            state_d    = ST_CONVERT;
            core_start = 1'b1;
          end else begin
            cnt_d = cnt_q + 2'h1;
          end
        end
      end
      ST_CONVERT: begin
        if (core_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // disabling aborts any activity without raising flags unless conv_end falls in the same cycle; the write that clears
    // enable already returns to idle so busy never outlives the enable bit
    if (!en_d) begin
      state_d    = ST_IDLE;
      core_start = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      cnt_q      <= 2'h0;
      ext_prev_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      ext_prev_q <= ext_prev_d;
    end
  end

  // control register, flags and result
  always_comb begin
    en_d     = en_q;
    tm_d     = tm_q;
    cm_d     = cm_q;
    done_d   = done_q;
    win_d    = win_q;
    result_d = result_q;
    if (ctrl_wr) begin
      en_d   = sfr_wdata[ADCSW_EN_BIT];
      tm_d   = sfr_wdata[ADCSW_TM_BIT];
      cm_d   = sfr_wdata[ADCSW_CM_LSB +: ADCSW_CM_W];
      done_d = sfr_wdata[ADCSW_DONE_BIT];
      win_d  = sfr_wdata[ADCSW_WIN_BIT];
    end
    // hardware set wins over a software clear in the same cycle
    if (conv_end) begin
      done_d   = 1'b1;
      result_d = core_result;
      if (win_match) begin
        win_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_q     <= ADCSW_CTRL_RESET[ADCSW_EN_BIT];
      tm_q     <= ADCSW_CTRL_RESET[ADCSW_TM_BIT];
      cm_q     <= ADCSW_CTRL_RESET[ADCSW_CM_LSB +: ADCSW_CM_W];
      done_q   <= ADCSW_CTRL_RESET[ADCSW_DONE_BIT];
      win_q    <= ADCSW_CTRL_RESET[ADCSW_WIN_BIT];
      result_q <= '0;
    end else begin
      en_q     <= en_d;
      tm_q     <= tm_d;
      cm_q     <= cm_d;
      done_q   <= done_d;
      win_q    <= win_d;
      result_q <= result_d;
    end
  end

  always_comb begin
    sfr_rdata = 8'h00;
    if (sfr_addr == ADCSW_CTRL_ADDR) begin
      sfr_rdata = {en_q, tm_q, done_q, busy, win_q, cm_q};
    end
  end

  assign core_enable = en_q;
  // tracking: continuous when idle with tm clear, or pin low, or the timed window
  always_comb begin
    core_track = 1'b0;
    if (en_q && state_q == ST_IDLE) begin
      if (!tm_q) begin
        core_track = 1'b1;
      end else if (cm_q == ADCSW_CM_EXT_PIN) begin
        core_track = !ext_sync;
      end
    end else if (en_q && state_q == ST_TRACK) begin
      core_track = 1'b1;
    end
  end
  assign conversion_result = result_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_shutdown;
    !en_q |-> !core_enable && !busy && !core_track;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("active while disabled");

  property p_track_cont;
    en_q && !tm_q && state_q == ST_IDLE |-> core_track;
  endproperty
  a_track_cont: assert property (p_track_cont) else $error("no continuous tracking");

  property p_busy_read;
    sfr_addr == ADCSW_CTRL_ADDR |-> sfr_rdata[ADCSW_BUSY_BIT] == (state_q == ST_CONVERT);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit wrong");

  property p_done_set;
    conv_end |=> done_q && !busy;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_busy_write;
    en_q && !tm_q && cm_q == ADCSW_CM_BUSY_WRITE && state_q == ST_IDLE && busy_wr
      && sfr_wdata[ADCSW_EN_BIT] |=> busy;
  endproperty
  a_busy_write: assert property (p_busy_write) else $error("busy write ignored");

  property p_timer0;
    en_q && !tm_q && cm_q == ADCSW_CM_TIMER0 && state_q == ST_IDLE && timer0_ovf
      && !ctrl_wr |=> busy;
  endproperty
  a_timer0: assert property (p_timer0) else $error("timer 0 trigger missed");

  property p_lp_track;
    state_q == ST_TRACK && state_d == ST_CONVERT |-> cnt_q == 2'h2 && sar_clk_tick;
  endproperty
  a_lp_track: assert property (p_lp_track) else $error("track length wrong");

  property p_ext_lp;
    en_q && tm_q && cm_q == ADCSW_CM_EXT_PIN && state_q == ST_IDLE
      |-> core_track == !ext_sync;
  endproperty
  a_ext_lp: assert property (p_ext_lp) else $error("pin tracking wrong");

  property p_win_sticky;
    win_q && !ctrl_wr |=> win_q;
  endproperty
  a_win_sticky: assert property (p_win_sticky) else $error("window flag lost");

  property p_result;
    conv_end |=> conversion_result == $past(core_result);
  endproperty
  a_result: assert property (p_result) else $error("result not captured");

  property p_inside;
    conv_end && !window_outside && core_result > greater_than_limit
      && core_result < less_than_limit |=> win_q;
  endproperty
  a_inside: assert property (p_inside) else $error("inside match missed");

  property p_outside;
    conv_end && window_outside && core_result < greater_than_limit |=> win_q;
  endproperty
  a_outside: assert property (p_outside) else $error("outside match missed");

  property p_win_once;
    !win_q && !conv_end && !(ctrl_wr && sfr_wdata[ADCSW_WIN_BIT]) |=> !win_q;
  endproperty
  a_win_once: assert property (p_win_once) else $error("window flag set idle");

  property p_cov_lp;
    state_q == ST_TRACK ##[1:40] conv_end;
  endproperty
  c_cov_lp: cover property (p_cov_lp);

  property p_cov_ext;
    ext_rise && cm_q == ADCSW_CM_EXT_PIN ##[1:40] conv_end;
  endproperty
  c_cov_ext: cover property (p_cov_ext);

  property p_cov_win;
    conv_end && win_match;
  endproperty
  c_cov_win: cover property (p_cov_win);

endmodule : adcsw_ctrl

/* testbench/adcsw_core_model.sv */
`timescale 1ns/1ps
module adcsw_core_model #(
  parameter int LAT = 12
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       core_enable,
  input  wire logic       core_start,
  input  wire logic [9:0] res_in,
  output logic            core_done,
  output logic [9:0]      core_result,
  output logic            sar_clk_tick
);
  int         cnt;
  logic [1:0] div;

  // result word only holds its value in the done cycle
  assign core_result = core_done ? res_in : ~res_in;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      div <= 2'h0;
      core_done <= 1'b0;
      sar_clk_tick <= 1'b0;
    end else begin
      div <= div + 2'h1;
      sar_clk_tick <= (div == 2'h3);
      core_done <= core_enable && (cnt == 1);
      if (!core_enable) begin
        cnt <= 0;
      end else if (core_start) begin
        cnt <= LAT;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : adcsw_core_model

/* testbench/adcsw_ctrl_tb.sv */
`timescale 1ns/1ps
module adcsw_ctrl_tb;
  import adcsw_pkg::*;
  logic        mclk, rst_n, sfr_wr, window_outside, pin, core_done, tick;
  logic        core_enable, core_track, core_start;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  logic [3:0]  tmr;
  logic [9:0]  lt, gt, res, core_result, conversion_result;
  // {tm, cm, outside, win, result}
  logic [15:0] rows [12] = '{16'h0464, 16'h1040, 16'h2080, 16'h3c3f, 16'h4c81, 16'h5840,
                             16'h8fff, 16'h9c00, 16'hc441, 16'hd47f, 16'ha3ff, 16'hb850};
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n_start = 0;

  adcsw_ctrl dut (.mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .window_outside(window_outside),
    .less_than_limit(lt), .greater_than_limit(gt), .timer0_ovf(tmr[0]),
    .timer1_ovf(tmr[1]), .timer2_ovf(tmr[2]), .timer3_ovf(tmr[3]),
    .external_start_pin(pin), .sar_clk_tick(tick), .core_done(core_done),
    .core_result(core_result), .core_enable(core_enable), .core_track(core_track),
    .core_start(core_start), .conversion_result(conversion_result));

  adcsw_core_model core (.mclk(mclk), .rst_n(rst_n), .core_enable(core_enable),
    .core_start(core_start), .res_in(res), .core_done(core_done),
    .core_result(core_result), .sar_clk_tick(tick));

  task automatic conclude();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
    sfr_addr = 8'he8;
  endtask : wr

  // timer codes pulse their timer; reserved codes pulse every timer
  task automatic fire(input logic [2:0] cm, input logic [7:0] ctrl);
    case (cm)
      3'h0: wr(8'he8, ctrl | 8'h10);
      3'h4: begin
        pin = 1'b0;
        repeat (4) @(negedge mclk);
        chk(10'(core_track), 10'h001);
        pin = 1'b1;
      end
      default: begin
        @(negedge mclk);
        tmr = (cm == 3'h1) ? 4'h1 : (cm == 3'h2) ? 4'h4 : (cm == 3'h3) ? 4'h2 :
              (cm == 3'h5) ? 4'h8 : 4'hf;
        @(negedge mclk);
        tmr = 4'h0;
      end
    endcase
  endtask : fire

  task automatic wait_done();
    for (int i = 0; i < 100 && sfr_rdata[5] !== 1'b1; i++) @(negedge mclk);
  endtask : wait_done

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (core_start === 1'b1) n_start++;
    if (cyc == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    rst_n = 1'b0;
    sfr_wr = 1'b0;
    sfr_addr = 8'he8;
    sfr_wdata = 8'h00;
    window_outside = 1'b0;
    pin = 1'b1;
    tmr = 4'h0;
    res = 10'h000;
    gt = 10'h040;
    lt = 10'h080;
    repeat (20) @(negedge mclk);
    chk(10'(sfr_rdata), 10'(ADCSW_CTRL_RESET));
    chk(10'(core_enable), 10'h000);
    rst_n = 1'b1;
    @(negedge mclk);
    for (int r = 0; r < 12; r++) begin
      logic [7:0] c;
      c = {1'b1, rows[r][15], 3'h0, rows[r][14:12]};
      res = rows[r][9:0];
      window_outside = rows[r][11];
      wr(8'he8, c);
      chk(10'(core_enable), 10'h001);
      chk(10'(core_track), 10'(!c[6]));
      fire(c[2:0], c);
      if (c[2:0] != 3'h4) begin
        chk(10'(sfr_rdata[4]), 10'(!c[6]));
        chk(10'(core_track), 10'(c[6]));
      end
      wait_done();
      chk(10'(sfr_rdata[5:4]), 10'h002);
      chk(10'(sfr_rdata[3]), 10'(rows[r][10]));
      chk(conversion_result, res);
    end
    wr(8'he8, 8'h85);
    wr(8'h55, 8'h00);
    chk(10'(core_enable), 10'h001);
    @(negedge mclk);
    sfr_addr = 8'h55;
    #1 chk(10'(sfr_rdata), 10'h000);
    sfr_addr = 8'he8;
    // busy write refused outside start mode zero
    wr(8'he8, 8'h95);
    chk(10'(sfr_rdata[4]), 10'h000);
    wr(8'he8, 8'h86);
    fire(3'h6, 8'h86);
    fire(3'h4, 8'h86);
    repeat (4) @(negedge mclk);
    chk(10'(sfr_rdata[4]), 10'h000);
    wr(8'he8, 8'h80);
    chk(10'(sfr_rdata[4]), 10'h000);
    res = 10'h064;
    window_outside = 1'b0;
    wr(8'he8, 8'h90);
    wait_done();
    chk(10'(sfr_rdata[3]), 10'h001);
    res = 10'h200;
    wr(8'he8, 8'h98);
    wait_done();
    chk(10'(sfr_rdata[3]), 10'h001);
    chk(conversion_result, 10'h200);
    // disabling mid-conversion aborts without raising flags
    wr(8'he8, 8'h90);
    wr(8'he8, 8'h00);
    repeat (20) @(negedge mclk);
    chk(10'(sfr_rdata), 10'h000);
    chk(10'(core_enable), 10'h000);
    // twelve row conversions, two flag conversions and one aborted one
    chk(10'(n_start), 10'h00f);
    conclude();
  end
endmodule : adcsw_ctrl_tb
